// ===== dv/pdn_props.sv
/*
  Assertion checker of the power-down sequencer, bound to its top ports.
  Assumes opcodes are only issued while the CPU runs.
*/
`timescale 1ns/1ps
`default_nettype none

module pdn_props (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Inputs
  input wire logic op_exec,
  input wire logic [7:0] op_code,
  input wire logic int_n,
  input wire logic reset_pin_n,
  input wire logic step_hold_in,
  // Outputs
  input wire logic cpu_clk_en,
  input wire logic osc_enable,
  input wire logic cpu_hold,
  input wire logic step_pull_up,
  input wire logic step_pull_down,
  input wire logic irq_take,
  input wire logic cpu_reset,
  input wire logic [pdn_pkg::VECTOR_WIDTH-1:0] vector,
  input wire logic port_one_allow,
  input wire logic port_two_hi_allow,
  input wire logic port_two_lo_allow,
  input wire logic bus_port_allow,
  input wire logic ale_allow,
  input wire logic code_fetch_strobe_allow,
  input wire logic expander_strobe_allow,
  input wire logic rd_allow,
  input wire logic wr_allow,
  input wire logic test_zero_pin_allow
);
  logic run_op;
  logic [9:0] allow;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // Opcode only counts with the CPU running and both wake pins quiet
  assign run_op = op_exec && int_n && reset_pin_n && cpu_clk_en && !cpu_hold;
  assign allow = {port_one_allow, port_two_hi_allow, port_two_lo_allow, bus_port_allow, ale_allow,
    code_fetch_strobe_allow, expander_strobe_allow, rd_allow, wr_allow, test_zero_pin_allow};

  AST_GATE: assert property (run_op && op_code == 8'h01 |=> !cpu_clk_en && osc_enable)
    else $error("clock gate opcode wrong");
  AST_STOP: assert property (run_op && op_code == 8'h82 |=>
    !osc_enable && !cpu_clk_en && step_pull_down && !step_pull_up)
    else $error("oscillator stop opcode wrong");
  AST_STAY: assert property (!cpu_clk_en && int_n && reset_pin_n |=> !cpu_clk_en)
    else $error("left halt without wake pin");
  AST_GATE_WAKE: assert property (!cpu_clk_en && osc_enable && !int_n |=> cpu_clk_en && !cpu_hold)
    else $error("gate wake not immediate");
  AST_STOP_WAKE: assert property (!osc_enable && !int_n && reset_pin_n |=>
    osc_enable && cpu_hold && step_pull_up)
    else $error("stop wake without hold");
  AST_HOLD: assert property (cpu_hold && !step_hold_in |=> cpu_hold)
    else $error("hold ended with step-hold low");
  AST_PORT: assert property (run_op && op_code == 8'ha2 ##1 int_n && reset_pin_n |=>
    allow[9:8] == 2'b00 && allow[5:0] == 6'h3f)
    else $error("port float pins wrong");
  AST_FLOAT_END: assert property (!(int_n && reset_pin_n) |-> ##2 allow == 10'h3ff)
    else $error("float not ended by wake pin");
  AST_IRQ_VEC: assert property (irq_take |-> vector == pdn_pkg::IRQ_VECTOR && !cpu_reset ##1 !irq_take)
    else $error("interrupt vector wrong");
  AST_RST_VEC: assert property (cpu_reset |-> vector == pdn_pkg::RESET_VECTOR && !irq_take ##1 !cpu_reset)
    else $error("reset vector wrong");
endmodule

`default_nettype wire

// ===== dv/tb_top.sv
/*
  Self-checking bench of the power-down sequencer.
  Assumes the board model supplies step-hold and address-latch pulses.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct packed {logic [7:0] op; logic ext; logic t0; logic [9:0] allow;} row_type;
  logic clk = 1'b0, srst = 1'b1, op_exec = 1'b0, in_service = 1'b0, int_n = 1'b1, reset_pin_n = 1'b1;
  logic [7:0] op_code = 8'h00;
  logic external_fetch_select = 1'b0, t0_clk_out_en = 1'b0, step_hold_in, ale_pulse;
  logic cpu_clk_en, osc_enable, cpu_hold, step_pull_up, step_pull_down, irq_take, cpu_reset, resume_next;
  logic [11:0] vector;
  logic irq_enabled, port_one_allow, port_two_hi_allow, port_two_lo_allow, bus_port_allow, ale_allow;
  logic code_fetch_strobe_allow, expander_strobe_allow, rd_allow, wr_allow, test_zero_pin_allow;
  logic [11:0] allow;
  int failures = 0, tests_run = 0, cycles = 0;
  // Float rows: opcode, ROM mode, clock-out flag, expected pin permission
  row_type rows [6] = '{'{8'ha2, 1'b0, 1'b1, 10'h03f}, '{8'ha2, 1'b1, 1'b0, 10'h0ff},
    '{8'hc2, 1'b0, 1'b1, 10'h000}, '{8'hc2, 1'b0, 1'b0, 10'h001},
    '{8'hc2, 1'b1, 1'b1, 10'h0f0}, '{8'hc2, 1'b1, 1'b0, 10'h0f1}};

  assign allow = {2'b00, port_one_allow, port_two_hi_allow, port_two_lo_allow, bus_port_allow, ale_allow,
    code_fetch_strobe_allow, expander_strobe_allow, rd_allow, wr_allow, test_zero_pin_allow};

  always #12.5 clk = ~clk;

  mcu_software_power_down mcu_software_power_down_inst (.clk, .srst, .op_exec, .op_code, .in_service,
    .int_n, .reset_pin_n, .step_hold_in, .external_fetch_select, .t0_clk_out_en, .ale_pulse,
    .cpu_clk_en, .osc_enable, .cpu_hold, .step_pull_up, .step_pull_down, .irq_take, .cpu_reset,
    .resume_next, .vector, .irq_enabled, .port_one_allow, .port_two_hi_allow, .port_two_lo_allow,
    .bus_port_allow, .ale_allow, .code_fetch_strobe_allow, .expander_strobe_allow, .rd_allow,
    .wr_allow, .test_zero_pin_allow);

  wake_board_model wake_board_model_inst (.clk, .srst, .cpu_clk_en, .cpu_hold, .step_pull_up,
    .step_pull_down, .step_hold_in, .ale_pulse);

  task automatic summarize();
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  // Opcode strobe for one cycle, then let the outputs settle
  task automatic op(input logic [7:0] code);
    op_code = code;
    op_exec = 1'b1;
    @(negedge clk);
    op_exec = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // Hold a wake pin low until the outcome pulse shows, bounded
  task automatic wake(input logic rst_pin, output logic [2:0] got, output logic [11:0] vec);
    int i;
    reset_pin_n = !rst_pin;
    int_n = rst_pin;
    got = 3'b000;
    vec = 12'h000;
    for (i = 0; i < 300 && got == 3'b000; i++) begin
      @(negedge clk);
      got = {irq_take, cpu_reset, resume_next};
      vec = vector;
    end
    int_n = 1'b1;
    reset_pin_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    logic [2:0] got;
    logic [11:0] vec;
    int k;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    check({5'h00, cpu_clk_en, osc_enable, cpu_hold, step_pull_up, step_pull_down, irq_enabled, resume_next},
      12'h068, "reset state");
    check(allow, 12'h3ff, "reset allow");
    // Every float opcode in both ROM modes, then cancel
    for (k = 0; k < 6; k++) begin
      external_fetch_select = rows[k].ext;
      t0_clk_out_en = rows[k].t0;
      op(rows[k].op);
      check(allow, {2'b00, rows[k].allow}, "float map");
      op(pdn_pkg::FLOAT_CANCEL_CODE_DEFAULT);
      check(allow, 12'h3ff, "float cancel");
    end
    external_fetch_select = 1'b0;
    t0_clk_out_en = 1'b0;
    // Interrupts on: gate wake vectors, inside a routine it resumes
    op(pdn_pkg::IRQ_ENABLE_CODE_DEFAULT);
    op(pdn_pkg::CLOCK_GATE_CODE);
    check({10'h000, cpu_clk_en, osc_enable}, 12'h001, "gate clocks");
    wake(1'b0, got, vec);
    check({got, 9'h000} | vec, 12'h803, "gate irq");
    in_service = 1'b1;
    op(pdn_pkg::CLOCK_GATE_CODE);
    wake(1'b0, got, vec);
    in_service = 1'b0;
    check({9'h000, got}, 12'h001, "service resume");
    // Port float under gate; a pin released before two pulses resumes
    op(pdn_pkg::PORT_FLOAT_CODE);
    op(pdn_pkg::CLOCK_GATE_CODE);
    check(allow, 12'h03f, "float while gated");
    int_n = 1'b0;
    @(negedge clk);
    int_n = 1'b1;
    @(negedge clk);
    check({9'h000, irq_take, cpu_reset, resume_next}, 12'h001, "short wake");
    repeat (2) @(negedge clk);
    check(allow, 12'h3ff, "short wake float");
    // Port float then oscillator stop, interrupt wake through step-hold
    op(pdn_pkg::PORT_FLOAT_CODE);
    op(pdn_pkg::OSC_STOP_CODE);
    check({8'h00, osc_enable, cpu_clk_en, step_pull_up, step_pull_down}, 12'h001, "stop");
    check(allow, 12'h03f, "float while stopped");
    wake(1'b0, got, vec);
    check({got, 9'h000} | vec, 12'h803, "stop irq");
    check({11'h000, irq_enabled}, 12'h001, "enable kept");
    check(allow, 12'h3ff, "float ended");
    // All-output float then stop, reset wake clears the enable
    op(pdn_pkg::ALL_FLOAT_CODE);
    op(pdn_pkg::OSC_STOP_CODE);
    wake(1'b1, got, vec);
    check({got, 9'h000} | vec, 12'h400, "stop reset");
    check({11'h000, irq_enabled}, 12'h000, "reset clears enable");
    // Interrupts off: all-output float then gate resumes next
    op(pdn_pkg::IRQ_DISABLE_CODE_DEFAULT);
    op(pdn_pkg::ALL_FLOAT_CODE);
    op(pdn_pkg::CLOCK_GATE_CODE);
    repeat (20) @(negedge clk);
    check({11'h000, cpu_clk_en}, 12'h000, "gate holds");
    wake(1'b0, got, vec);
    check({9'h000, got}, 12'h001, "gate resume");
    summarize();
  end
endmodule

bind mcu_software_power_down pdn_props pdn_props_inst (.clk, .srst, .op_exec, .op_code, .int_n,
  .reset_pin_n, .step_hold_in, .cpu_clk_en, .osc_enable, .cpu_hold, .step_pull_up, .step_pull_down,
  .irq_take, .cpu_reset, .vector, .port_one_allow, .port_two_hi_allow, .port_two_lo_allow,
  .bus_port_allow, .ale_allow, .code_fetch_strobe_allow, .expander_strobe_allow, .rd_allow,
  .wr_allow, .test_zero_pin_allow);

`default_nettype wire

// ===== dv/wake_board_model.sv
/*
  Board side: step-hold capacitor and address-latch pulse source.
  Assumes pulls come from the device and pulses stop while the CPU waits.
*/
`timescale 1ns/1ps
`default_nettype none

module wake_board_model #(
  parameter int CHARGE = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // From the device
  input wire logic cpu_clk_en,
  input wire logic cpu_hold,
  input wire logic step_pull_up,
  input wire logic step_pull_down,
  // To the device
  output logic step_hold_in,
  output logic ale_pulse
);
  logic [7:0] charge_reg;
  logic [1:0] div_reg;

  // Capacitor: pull-down empties it, pull-up fills it slowly
  always_ff @(negedge clk) begin
    if (srst || step_pull_down || !step_pull_up)
      charge_reg <= 8'h00;
    else if (charge_reg != CHARGE[7:0])
      charge_reg <= charge_reg + 8'h01;
  end
  assign step_hold_in = (charge_reg == CHARGE[7:0]);

  // One pulse per three clocks, only while the CPU really runs
  // Divider is reset, else an unknown phase poisons the wake counters
  always_ff @(negedge clk) begin
    if (srst) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
    end
    ale_pulse <= (div_reg == 2'h2) && cpu_clk_en && !cpu_hold && !srst;
  end
endmodule

`default_nettype wire

// ===== rtl/ale_hold_counter.sv
/*
  Counts address-latch pulses seen while a wake pin stays low.
  Assumes ale_pulse is a one-cycle pulse on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ale_hold_counter #(
  parameter int TARGET = pdn_pkg::WAKE_ALE_COUNT,
  parameter int CNT_WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic clear,
  input wire logic ale_pulse,
  input wire logic pin_low,
  // Result
  output logic reached
);

  logic [CNT_WIDTH-1:0] count_reg;

  // A high pin restarts the count; saturates at the target
  always_ff @(posedge clk) begin
    if (srst || clear || !pin_low) begin
      count_reg <= '0;
    end else if (ale_pulse && !reached) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign reached = pin_low && (count_reg >= CNT_WIDTH'(TARGET));

endmodule

`default_nettype wire

// ===== rtl/float_map_if.sv
/*
  Carrier between the sequencer and its pin float map.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

interface float_map_if;
  pdn_pkg::float_mode_type mode;
  logic ext_rom;
  logic t0_clk_out;
  pdn_pkg::pin_allow_type allow;

  modport ctrl (output mode, output ext_rom, output t0_clk_out, input allow);
  modport map (input mode, input ext_rom, input t0_clk_out, output allow);
endinterface

`default_nettype wire

// ===== rtl/float_pin_map.sv
/*
  Maps the float mode and ROM mode to per-pin drive permission.
  Purely combinational; the sequencer registers the result.
*/
`timescale 1ns/1ps
`default_nettype none

module float_pin_map (
  float_map_if.map fm
);

  // Strobes and test pin survive the port float; ext ROM keeps its fetch path
  always_comb begin
    fm.allow = pdn_pkg::ALLOW_ALL;
    unique case (fm.mode)
      pdn_pkg::FLOAT_NONE: begin
        fm.allow = pdn_pkg::ALLOW_ALL;
      end
      pdn_pkg::FLOAT_PORTS: begin
        fm.allow.port_one = 1'b0; // [R6]
        fm.allow.port_two_hi = 1'b0; // [R6]
        fm.allow.port_two_lo = fm.ext_rom; // [R6]
        fm.allow.bus_port = fm.ext_rom; // [R6]
      end
      pdn_pkg::FLOAT_ALL: begin
        fm.allow.port_one = 1'b0;
        fm.allow.port_two_hi = 1'b0;
        fm.allow.port_two_lo = fm.ext_rom; // [R9]
        fm.allow.bus_port = fm.ext_rom; // [R8]
        fm.allow.ale = fm.ext_rom; // [R9]
        fm.allow.fetch = fm.ext_rom; // [R9]
        fm.allow.expander = 1'b0; // [R8]
        fm.allow.rd = 1'b0; // [R8]
        fm.allow.wr = 1'b0; // [R8]
        fm.allow.test_zero = !fm.t0_clk_out; // [R10]
      end
      default: begin
        fm.allow = pdn_pkg::ALLOW_ALL;
      end
    endcase
  end

endmodule

`default_nettype wire

// ===== rtl/mcu_software_power_down.sv
/*
  Software power-down sequencer of a small microcontroller: decodes the
  power-down opcodes, gates the CPU clock or stops the oscillator, floats
  pin groups, and qualifies wake-up on the interrupt and reset pins.
  Assumes the CPU reports each executed opcode as a one-cycle strobe, and
  produces one ale_pulse per machine cycle while its clock runs.
*/
// How it works
// [R1] Clock-gate opcode stops CPU clock, oscillator runs
// [R2] Clock-gate wake resumes without stabilisation wait
// [R3] Oscillator-stop opcode halts oscillator and CPU
// [R4] Interrupt wake from stop waits step-hold high
// [R5] Either float opcode combines with either halt
// [R6] Port float: ports float, ext ROM keeps some
// [R7] Port float keeps strobes and test pin
// [R8] All-float internal ROM floats strobes, ports, bus
// [R9] All-float external ROM keeps fetch path alive
// [R10] Test pin floats only as clock output
// [R11] Float ends on cancel, interrupt or reset low
// [R12] Power-down left only by interrupt/reset low
// [R13] Enabled interrupt held two pulses vectors three
// [R14] Power-down inside service routine resumes next
// [R15] Disabled interrupt held two pulses resumes next
// [R16] Reset held two pulses resets, starts zero
// [R17] Board holds reset until oscillator stable
// [R18] Step-hold pulled low while halted, up after; pulled low only after the oscillator-stop opcode, not the clock gate
// [R19] State retained through power-down unless reset
`timescale 1ns/1ps
`default_nettype none

module mcu_software_power_down #(
  parameter logic [7:0] FLOAT_CANCEL_CODE = pdn_pkg::FLOAT_CANCEL_CODE_DEFAULT,
  parameter logic [7:0] IRQ_ENABLE_CODE = pdn_pkg::IRQ_ENABLE_CODE_DEFAULT,
  parameter logic [7:0] IRQ_DISABLE_CODE = pdn_pkg::IRQ_DISABLE_CODE_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Opcode strobe from the CPU
  input wire logic op_exec,
  input wire logic [7:0] op_code,
  input wire logic in_service,
  // Pins and CPU status
  input wire logic int_n,
  input wire logic reset_pin_n,
  input wire logic step_hold_in,
  input wire logic external_fetch_select,
  input wire logic t0_clk_out_en,
  input wire logic ale_pulse,
  // Clock control
  output logic cpu_clk_en,
  output logic osc_enable,
  output logic cpu_hold,
  output logic step_pull_up,
  output logic step_pull_down,
  // Wake actions
  output logic irq_take,
  output logic cpu_reset,
  output logic resume_next,
  output logic [pdn_pkg::VECTOR_WIDTH-1:0] vector,
  output logic irq_enabled,
  // Pin drive permission
  output logic port_one_allow,
  output logic port_two_hi_allow,
  output logic port_two_lo_allow,
  output logic bus_port_allow,
  output logic ale_allow,
  output logic code_fetch_strobe_allow,
  output logic expander_strobe_allow,
  output logic rd_allow,
  output logic wr_allow,
  output logic test_zero_pin_allow
);

  typedef enum logic [2:0] {
    RUN,
    CLK_GATED,
    OSC_STOPPED,
    STEP_WAIT,
    QUALIFY
  } state_type;

  state_type state_reg;
  pdn_pkg::float_mode_type float_reg;
  pdn_pkg::pin_allow_type allow_reg;
  logic irq_en_reg;
  logic isr_entry_reg;
  logic cpu_clk_en_reg;
  logic osc_enable_reg;
  logic cpu_hold_reg;
  logic pull_up_reg;
  logic pull_down_reg;
  logic irq_take_reg;
  logic cpu_reset_reg;
  logic resume_reg;
  logic [pdn_pkg::VECTOR_WIDTH-1:0] vector_reg;

  logic int_low;
  logic rst_low;
  logic wake;
  logic in_power_down;
  logic int_reached;
  logic rst_reached;
  logic op_gate;
  logic op_stop;
  logic qualify_done;

  float_map_if fm ();

  assign int_low = !int_n;
  assign rst_low = !reset_pin_n;
  assign wake = int_low || rst_low;
  assign in_power_down = (state_reg == CLK_GATED) || (state_reg == OSC_STOPPED);
  assign op_gate = op_exec && (state_reg == RUN) && (op_code == pdn_pkg::CLOCK_GATE_CODE);
  assign op_stop = op_exec && (state_reg == RUN) && (op_code == pdn_pkg::OSC_STOP_CODE);
  assign qualify_done = (state_reg == QUALIFY) && (rst_reached || int_reached || !wake);

  // Wake qualifiers run only while the CPU produces address-latch pulses
  ale_hold_counter #(
    .TARGET(pdn_pkg::WAKE_ALE_COUNT),
    .CNT_WIDTH($clog2(pdn_pkg::WAKE_ALE_COUNT + 1))
  ) int_counter (
    .clk(clk),
    .srst(srst),
    .clear(state_reg != QUALIFY),
    .ale_pulse(ale_pulse),
    .pin_low(int_low),
    .reached(int_reached)
  );

  ale_hold_counter #(
    .TARGET(pdn_pkg::WAKE_ALE_COUNT),
    .CNT_WIDTH($clog2(pdn_pkg::WAKE_ALE_COUNT + 1))
  ) rst_counter (
    .clk(clk),
    .srst(srst),
    .clear(state_reg != QUALIFY),
    .ale_pulse(ale_pulse),
    .pin_low(rst_low),
    .reached(rst_reached)
  );

  assign fm.mode = float_reg;
  assign fm.ext_rom = external_fetch_select;
  assign fm.t0_clk_out = t0_clk_out_en;

  float_pin_map pin_map (
    .fm(fm.map)
  );

  // Power-down sequence; only a low wake pin leaves the halt states
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= RUN;
    end else begin
      unique case (state_reg)
        RUN: begin
          if (op_gate) begin
            state_reg <= CLK_GATED; // [R1]
          end else if (op_stop) begin
            state_reg <= OSC_STOPPED; // [R3]
          end
        end
        CLK_GATED: begin
          if (wake) begin
            state_reg <= QUALIFY; // [R2] [R12]
          end
        end
        OSC_STOPPED: begin
          // Reset wake relies on the board holding the pin low [R17]
          if (rst_low) begin
            state_reg <= QUALIFY; // [R12]
          end else if (int_low) begin
            state_reg <= STEP_WAIT; // [R4] [R12]
          end
        end
        STEP_WAIT: begin
          if (step_hold_in) begin
            state_reg <= QUALIFY; // [R4]
          end
        end
        QUALIFY: begin
          if (qualify_done) begin
            state_reg <= RUN;
          end
        end
      endcase
    end
  end

  // Float mode survives a following halt opcode; any low wake pin cancels
  always_ff @(posedge clk) begin
    if (srst) begin
      float_reg <= pdn_pkg::FLOAT_NONE;
    end else if (wake) begin
      float_reg <= pdn_pkg::FLOAT_NONE; // [R11]
    end else if (op_exec && state_reg == RUN) begin
      if (op_code == pdn_pkg::PORT_FLOAT_CODE) begin
        float_reg <= pdn_pkg::FLOAT_PORTS; // [R5] [R6]
      end else if (op_code == pdn_pkg::ALL_FLOAT_CODE) begin
        float_reg <= pdn_pkg::FLOAT_ALL; // [R5] [R8]
      end else if (op_code == FLOAT_CANCEL_CODE) begin
        float_reg <= pdn_pkg::FLOAT_NONE; // [R11]
      end
    end
  end

  // Registered pin permission; strobes stay on in port float
  always_ff @(posedge clk) begin
    if (srst) begin
      allow_reg <= pdn_pkg::ALLOW_ALL;
    end else begin
      allow_reg <= fm.allow; // [R7]
    end
  end

  // Interrupt enable kept across power-down, cleared by reset wake or the disable opcode
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_en_reg <= pdn_pkg::IRQ_ENABLE_RESET;
    end else if (qualify_done && rst_reached) begin
      irq_en_reg <= pdn_pkg::IRQ_ENABLE_RESET; // [R16]
    end else if (op_exec && state_reg == RUN && op_code == IRQ_ENABLE_CODE) begin
      irq_en_reg <= 1'b1;
    end else if (op_exec && state_reg == RUN && op_code == IRQ_DISABLE_CODE) begin
      irq_en_reg <= 1'b0; // [R19]
    end
  end

  // Remember whether the halt came from inside a service routine
  always_ff @(posedge clk) begin
    if (srst) begin
      isr_entry_reg <= 1'b0;
    end else if (op_gate || op_stop) begin
      isr_entry_reg <= in_service; // [R14]
    end
  end

  // Clock gating and oscillator; a clock-gate wake restarts at once
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_clk_en_reg <= pdn_pkg::CPU_CLK_EN_RESET;
      osc_enable_reg <= pdn_pkg::OSC_ENABLE_RESET;
    end else if (op_gate) begin
      cpu_clk_en_reg <= 1'b0; // [R1]
    end else if (op_stop) begin
      cpu_clk_en_reg <= 1'b0; // [R3]
      osc_enable_reg <= 1'b0; // [R3]
    end else if (in_power_down && wake) begin
      cpu_clk_en_reg <= 1'b1; // [R2] [R12]
      osc_enable_reg <= 1'b1; // [R12]
    end
  end

  // CPU held until the step-hold capacitor charges past threshold
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_hold_reg <= 1'b0;
    end else if (state_reg == OSC_STOPPED && int_low && !rst_low) begin
      cpu_hold_reg <= 1'b1; // [R4]
    end else if (state_reg == STEP_WAIT && step_hold_in) begin
      cpu_hold_reg <= 1'b0; // [R4]
    end
  end

  // Weak pull-down only while the oscillator is halted
  always_ff @(posedge clk) begin
    if (srst) begin
      pull_down_reg <= 1'b0;
      pull_up_reg <= 1'b1;
    end else if (op_stop) begin
      pull_down_reg <= 1'b1; // [R18]
      pull_up_reg <= 1'b0; // [R18]
    end else if (state_reg == OSC_STOPPED && wake) begin
      pull_down_reg <= 1'b0; // [R18]
      pull_up_reg <= 1'b1; // [R18]
    end
  end

  // Wake outcome pulses; reset wins over an interrupt reaching together
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_take_reg <= 1'b0;
      cpu_reset_reg <= 1'b0;
      resume_reg <= 1'b0;
      vector_reg <= pdn_pkg::RESET_VECTOR;
    end else begin
      irq_take_reg <= 1'b0;
      cpu_reset_reg <= 1'b0;
      resume_reg <= 1'b0;
      if (qualify_done) begin
        if (rst_reached) begin
          cpu_reset_reg <= 1'b1; // [R16]
          vector_reg <= pdn_pkg::RESET_VECTOR; // [R16]
        end else if (int_reached && irq_en_reg && !isr_entry_reg) begin
          irq_take_reg <= 1'b1; // [R13]
          vector_reg <= pdn_pkg::IRQ_VECTOR; // [R13]
        end else begin
          resume_reg <= 1'b1; // [R14] [R15]
        end
      end
    end
  end

  assign cpu_clk_en = cpu_clk_en_reg;
  assign osc_enable = osc_enable_reg;
  assign cpu_hold = cpu_hold_reg;
  assign step_pull_up = pull_up_reg;
  assign step_pull_down = pull_down_reg;
  assign irq_take = irq_take_reg;
  assign cpu_reset = cpu_reset_reg;
  assign resume_next = resume_reg;
  assign vector = vector_reg;
  assign irq_enabled = irq_en_reg;
  assign port_one_allow = allow_reg.port_one;
  assign port_two_hi_allow = allow_reg.port_two_hi;
  assign port_two_lo_allow = allow_reg.port_two_lo;
  assign bus_port_allow = allow_reg.bus_port;
  assign ale_allow = allow_reg.ale;
  assign code_fetch_strobe_allow = allow_reg.fetch;
  assign expander_strobe_allow = allow_reg.expander;
  assign rd_allow = allow_reg.rd;
  assign wr_allow = allow_reg.wr;
  assign test_zero_pin_allow = allow_reg.test_zero;

endmodule

`default_nettype wire

// ===== rtl/pdn_pkg.sv
/*
  Shared constants and types of the software power-down block: opcodes,
  wake vectors, wake qualification count, float modes and pin-allow layout.
  Assumes a 40 MHz single clock and no software-visible registers.
*/
`default_nettype none

package pdn_pkg;

  // Opcodes decoded by the sequencer
  localparam logic [7:0] CLOCK_GATE_CODE = 8'h01;
  localparam logic [7:0] OSC_STOP_CODE = 8'h82;
  localparam logic [7:0] PORT_FLOAT_CODE = 8'ha2;
  localparam logic [7:0] ALL_FLOAT_CODE = 8'hc2;
  // Codes not fixed here; arbitrary defaults, overridable at the top
  localparam logic [7:0] FLOAT_CANCEL_CODE_DEFAULT = 8'he2;
  localparam logic [7:0] IRQ_ENABLE_CODE_DEFAULT = 8'h05;
  localparam logic [7:0] IRQ_DISABLE_CODE_DEFAULT = 8'h15;

  // Wake qualification and restart addresses
  localparam int WAKE_ALE_COUNT = 2;
  localparam int VECTOR_WIDTH = 12;
  localparam logic [11:0] IRQ_VECTOR = 12'h003;
  localparam logic [11:0] RESET_VECTOR = 12'h000;

  // Reset values of control state
  localparam logic IRQ_ENABLE_RESET = 1'b0;
  localparam logic OSC_ENABLE_RESET = 1'b1;
  localparam logic CPU_CLK_EN_RESET = 1'b1;

  typedef enum logic [1:0] {
    FLOAT_NONE,
    FLOAT_PORTS,
    FLOAT_ALL
  } float_mode_type;

  // One bit per pin group; 1 lets the pin drive, 0 floats it
  typedef struct packed {
    logic port_one;
    logic port_two_hi;
    logic port_two_lo;
    logic bus_port;
    logic ale;
    logic fetch;
    logic expander;
    logic rd;
    logic wr;
    logic test_zero;
  } pin_allow_type;

  localparam pin_allow_type ALLOW_ALL = 10'h3ff;

endpackage

`default_nettype wire
